// *** logic/wrc_pkg.sv ***
// Package: constants, register map and types for the watchdog and reset control block
package wrc_pkg;

   // Register byte offsets on APB
   localparam logic [11:0] WRC_OFS_WDT_CTRL   = 12'h000;
   localparam logic [11:0] WRC_OFS_CAUSE      = 12'h004;
   localparam logic [11:0] WRC_OFS_LV_LEVEL   = 12'h008;
   localparam logic [11:0] WRC_OFS_LV_FILTER  = 12'h00C;
   localparam logic [11:0] WRC_OFS_STATUS     = 12'h010;
   localparam logic [11:0] WRC_OFS_COMMAND    = 12'h014;

   // Reset values
   localparam logic [7:0]  WRC_WDT_CTRL_RST   = 8'h53;
   localparam logic [7:0]  WRC_LV_LEVEL_RST   = 8'h55;
   localparam logic [1:0]  WRC_LV_FILTER_RST  = 2'h0;

   // Enable key patterns
   localparam logic [4:0]  WRC_KEY_EN_A       = 5'h0A;
   localparam logic [4:0]  WRC_KEY_EN_B       = 5'h15;

   // Voltage level codes
   localparam logic [7:0]  WRC_LV_2V10        = 8'h55;
   localparam logic [7:0]  WRC_LV_2V55        = 8'h33;
   localparam logic [7:0]  WRC_LV_3V15        = 8'h99;
   localparam logic [7:0]  WRC_LV_3V80        = 8'hAA;

   // Field positions
   localparam int          WRC_KEY_LSB        = 3;
   localparam int          WRC_FLAG_WKEY      = 0;
   localparam int          WRC_FLAG_LKEY      = 1;
   localparam int          WRC_FLAG_LV        = 2;
   localparam int          WRC_CMD_CLR        = 0;
   localparam int          WRC_CMD_HALT       = 1;
   localparam int          WRC_CMD_WAKE       = 2;
   localparam int          WRC_ST_EXPIRY      = 0;
   localparam int          WRC_ST_PDOWN       = 1;

   // Timing: slow oscillator and key fault delay
   localparam int          WRC_CLK_HZ         = 125_000_000;
   localparam int          WRC_SLOW_HZ        = 32_000;
   localparam int          WRC_SLOW_DIV       = WRC_CLK_HZ / WRC_SLOW_HZ;
   localparam int          WRC_KEY_DELAY_US   = 48;
   localparam int          WRC_KEY_DELAY_CYC  = (WRC_KEY_DELAY_US * 125 + 0) ;
   localparam int          WRC_WDT_W          = 18;

   // Filter lengths in slow ticks, lower bound of each band
   localparam logic [7:0]  WRC_FILT_0         = 8'h07;
   localparam logic [7:0]  WRC_FILT_1         = 8'h1F;
   localparam logic [7:0]  WRC_FILT_2         = 8'h3F;
   localparam logic [7:0]  WRC_FILT_3         = 8'h7F;

   // Control commands from the core
   typedef struct packed
   {
      logic wake;
      logic halt;
      logic clr;
   } wrc_cmd_t;

   // Reset requests out to the system
   typedef struct packed
   {
      logic full_rst;
      logic pc_sp_rst;
   } wrc_rst_t;

endpackage

// *** logic/wrc_top.sv ***
// Watchdog timer, low voltage reset qualifier and reset cause flags
//
// Behaviour
// - Watchdog overflow resets device unless cleared
// - Watchdog enabled only by two key patterns
// - Other key values reset after delay
// - Power-up loads first valid enable pattern
// - Key fault sets sticky flag, software clears
// - Running overflow resets and sets expiry
// - Idle overflow sets expiry, resets PC/SP
// - Key fault, clear or halt zeroes counter
// - Longest timeout uses largest division ratio
// - Power-on sets program counter to zero
// - Power-on sets port registers to ones
// - Qualified low supply resets, sets flag
// - Short low pulses are ignored entirely
// - Low voltage detection off in idle
// - Four level codes select thresholds
// - Bad level code resets, restores default
// - Bad level code sets sticky flag
// - Low voltage reset keeps level register
// - Filter field sets minimum low duration
// - Low voltage flag sticky until cleared
// - Unused upper flag bits read zero
// - Power-up loads lowest threshold code
// - Period select chooses division ratio
// - Counter runs from divided slow clock
//
// Chosen here: the address map and the APB slave port.
module wrc_top
(
   // Clock and reset
   input  wire logic               clk_sys_i,
   input  wire logic               reset_i,
   // APB slave
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [11:0]        paddr_i,
   input  wire logic [31:0]        pwdata_i,
   output logic      [31:0]        prdata_o,
   output logic                    pready_o,
   output logic                    pslverr_o,
   // Core events and analog comparator
   input  wire wrc_pkg::wrc_cmd_t  core_cmd_i,
   input  wire logic               supply_low_i,
   // Reset requests and threshold
   output wrc_pkg::wrc_rst_t       rst_req_o,
   output logic      [1:0]         lv_threshold_o,
   output logic                    port_init_o,
   output logic                    pc_zero_o
);
   import wrc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Registers and signals
   logic [4:0]           wdt_enable_key_r;
   logic [2:0]           period_select_r;
   logic [7:0]           lowvolt_level_reg_r;
   logic [1:0]           lowvolt_filter_sel_r;
   logic                 wdt_key_reset_flag_r;
   logic                 level_key_reset_flag_r;
   logic                 lowvolt_reset_flag_r;
   logic                 watchdog_expiry_flag_r;
   logic                 powerdown_flag_r;
   logic [15:0]          slow_div_r;
   logic                 slow_tick;
   logic [WRC_WDT_W-1:0] wdt_cnt_r;
   logic                 wdt_ovf;
   logic                 wdt_expire;
   logic                 any_fire;
   logic [15:0]          wkey_dly_r;
   logic [15:0]          lkey_dly_r;
   logic [7:0]           lv_cnt_r;
   logic [7:0]           lv_need;
   logic [1:0]           low_sync_r;
   logic                 key_ok;
   logic                 lvl_ok;
   logic                 wr_en;
   logic                 rd_en;
   logic                 addr_ok;
   logic                 wkey_fire;
   logic                 lkey_fire;
   logic                 lv_fire;
   logic                 clr_cause_we;
   logic [31:0]          cause_word;
   logic [31:0]          status_word;
   wrc_cmd_t             cmd;

   // Core events come on this clock, so they need no synchroniser
   assign cmd = core_cmd_i;

   ////////////////////////////////////////////////////////////////////////
   // Decode
   assign key_ok  = (wdt_enable_key_r == WRC_KEY_EN_A) ||
                    (wdt_enable_key_r == WRC_KEY_EN_B);
   assign lvl_ok  = (lowvolt_level_reg_r == WRC_LV_2V10) ||
                    (lowvolt_level_reg_r == WRC_LV_2V55) ||
                    (lowvolt_level_reg_r == WRC_LV_3V15) ||
                    (lowvolt_level_reg_r == WRC_LV_3V80);
   // Command word is mapped so it answers without error
   assign addr_ok = (paddr_i == WRC_OFS_WDT_CTRL) || (paddr_i == WRC_OFS_CAUSE) ||
                    (paddr_i == WRC_OFS_LV_LEVEL) || (paddr_i == WRC_OFS_LV_FILTER) ||
                    (paddr_i == WRC_OFS_STATUS)   || (paddr_i == WRC_OFS_COMMAND);
   // Access phase of one-wait-state slave: writes commit while pready_o is high, reads sample while it is low
   assign wr_en   = psel_i && penable_i && pready_o && pwrite_i && addr_ok;
   assign rd_en   = psel_i && penable_i && !pready_o && !pwrite_i;
   assign clr_cause_we = wr_en && (paddr_i == WRC_OFS_CAUSE);

   ////////////////////////////////////////////////////////////////////////
   // Slow oscillator tick, derived from system clock
   // Integer divide, so the tick runs a hair fast of the nominal rate
   assign slow_tick = (slow_div_r == 16'(WRC_SLOW_DIV - 1));

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || slow_tick)
         slow_div_r <= 16'h0000;
      else
         slow_div_r <= slow_div_r + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog counter: overflow at selected ratio
   always_comb
   begin
      case (period_select_r)
         3'h0:    wdt_ovf = &wdt_cnt_r[7:0];
         3'h1:    wdt_ovf = &wdt_cnt_r[9:0];
         3'h2:    wdt_ovf = &wdt_cnt_r[11:0];
         3'h3:    wdt_ovf = &wdt_cnt_r[13:0];
         3'h4:    wdt_ovf = &wdt_cnt_r[14:0];
         3'h5:    wdt_ovf = &wdt_cnt_r[15:0];
         3'h6:    wdt_ovf = &wdt_cnt_r[16:0];
         default: wdt_ovf = &wdt_cnt_r[17:0];
      endcase
   end

   // Overflow only counts on a tick with a valid key
   assign wdt_expire = slow_tick && key_ok && wdt_ovf;

   // Clearing sources share priority over counting
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || cmd.clr || cmd.halt || any_fire)
         wdt_cnt_r <= '0;
      else if (slow_tick && key_ok)
         wdt_cnt_r <= (wdt_ovf) ? '0 : wdt_cnt_r + WRC_WDT_W'(1);
   end

   ////////////////////////////////////////////////////////////////////////
   // Key fault delays: counting runs while key stays bad, clears once it is good
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || key_ok || wkey_fire)
         wkey_dly_r <= 16'h0000;
      else
         wkey_dly_r <= wkey_dly_r + 16'h0001;
   end
   assign wkey_fire = (wkey_dly_r == 16'(WRC_KEY_DELAY_CYC - 1));

   // Level key fault delay, same length as the watchdog key's
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || lvl_ok || lkey_fire)
         lkey_dly_r <= 16'h0000;
      else
         lkey_dly_r <= lkey_dly_r + 16'h0001;
   end
   assign lkey_fire = (lkey_dly_r == 16'(WRC_KEY_DELAY_CYC - 1));

   ////////////////////////////////////////////////////////////////////////
   // Low supply qualifier; comparator is asynchronous, sync first
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         low_sync_r <= 2'b00;
      else
         low_sync_r <= {low_sync_r[0], supply_low_i};
   end

   always_comb
   begin
      case (lowvolt_filter_sel_r)
         2'h0:    lv_need = WRC_FILT_0;
         2'h1:    lv_need = WRC_FILT_1;
         2'h2:    lv_need = WRC_FILT_2;
         default: lv_need = WRC_FILT_3;
      endcase
   end

   // Tick granularity gives the one-period band of the filter
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || !low_sync_r[1] || powerdown_flag_r || lv_fire)
         lv_cnt_r <= 8'h00;
      else if (slow_tick)
         lv_cnt_r <= lv_cnt_r + 8'h01;
   end
   // One count past the band's low end: the first tick lands anywhere in a period
   assign lv_fire = low_sync_r[1] && !powerdown_flag_r && (lv_cnt_r == lv_need + 8'h01);

   // Faults that end in a full reset also restart the watchdog count
   assign any_fire = wkey_fire || lkey_fire || lv_fire;

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   // Key field restored after a key fault so the watchdog restarts
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         wdt_enable_key_r <= WRC_WDT_CTRL_RST[7:WRC_KEY_LSB];
         period_select_r  <= WRC_WDT_CTRL_RST[WRC_KEY_LSB-1:0];
      end
      else if (wkey_fire)
      begin
         wdt_enable_key_r <= WRC_WDT_CTRL_RST[7:WRC_KEY_LSB];
         period_select_r  <= WRC_WDT_CTRL_RST[WRC_KEY_LSB-1:0];
      end
      else if (wr_en && paddr_i == WRC_OFS_WDT_CTRL)
      begin
         wdt_enable_key_r <= pwdata_i[7:WRC_KEY_LSB];
         period_select_r  <= pwdata_i[WRC_KEY_LSB-1:0];
      end
   end

   // Level register survives a genuine low voltage reset
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i || lkey_fire)
         lowvolt_level_reg_r <= WRC_LV_LEVEL_RST;
      else if (wr_en && paddr_i == WRC_OFS_LV_LEVEL)
         lowvolt_level_reg_r <= pwdata_i[7:0];
   end

   // Filter length select, two bits only
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         lowvolt_filter_sel_r <= WRC_LV_FILTER_RST;
      else if (wr_en && paddr_i == WRC_OFS_LV_FILTER)
         lowvolt_filter_sel_r <= pwdata_i[1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Sticky cause flags: set wins over software clear
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         wdt_key_reset_flag_r   <= 1'b0;
         level_key_reset_flag_r <= 1'b0;
         lowvolt_reset_flag_r   <= 1'b0;
      end
      else
      begin
         if (wkey_fire)
            wdt_key_reset_flag_r <= 1'b1;
         else if (clr_cause_we && !pwdata_i[WRC_FLAG_WKEY])
            wdt_key_reset_flag_r <= 1'b0;
         if (!lvl_ok)
            level_key_reset_flag_r <= 1'b1;
         else if (clr_cause_we && !pwdata_i[WRC_FLAG_LKEY])
            level_key_reset_flag_r <= 1'b0;
         if (lv_fire)
            lowvolt_reset_flag_r <= 1'b1;
         else if (clr_cause_we && !pwdata_i[WRC_FLAG_LV])
            lowvolt_reset_flag_r <= 1'b0;
      end
   end

   // Expiry and power-down flags follow the core's sequence
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         watchdog_expiry_flag_r <= 1'b0;
         powerdown_flag_r       <= 1'b0;
      end
      else
      begin
         // An expiry in the same cycle as a clear still counts
         if (wdt_expire)
            watchdog_expiry_flag_r <= 1'b1;
         else if (cmd.clr || cmd.halt)
            watchdog_expiry_flag_r <= 1'b0;
         // Halt marks power-down; clear or wake ends it
         if (cmd.halt)
            powerdown_flag_r <= 1'b1;
         else if (cmd.clr || cmd.wake)
            powerdown_flag_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset requests, one-cycle pulses
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         rst_req_o <= '0;
      else
      begin
         rst_req_o.full_rst  <= any_fire || (wdt_expire && !powerdown_flag_r);
         rst_req_o.pc_sp_rst <= wdt_expire && powerdown_flag_r;
      end
   end

   // Power-on indications; core zeroes PC and loads ports with ones
   always_ff @(posedge clk_sys_i)
   begin
      port_init_o <= reset_i;
      pc_zero_o   <= reset_i;
   end

   // Threshold select decoded from the level code
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         lv_threshold_o <= 2'h0;
      else
         case (lowvolt_level_reg_r)
            WRC_LV_2V55: lv_threshold_o <= 2'h1;
            WRC_LV_3V15: lv_threshold_o <= 2'h2;
            WRC_LV_3V80: lv_threshold_o <= 2'h3;
            default:     lv_threshold_o <= 2'h0;
         endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Flag words placed at their named bit positions; others read zero
   always_comb
   begin
      cause_word                 = 32'h0000_0000;
      cause_word[WRC_FLAG_WKEY]  = wdt_key_reset_flag_r;
      cause_word[WRC_FLAG_LKEY]  = level_key_reset_flag_r;
      cause_word[WRC_FLAG_LV]    = lowvolt_reset_flag_r;
      status_word                = 32'h0000_0000;
      status_word[WRC_ST_EXPIRY] = watchdog_expiry_flag_r;
      status_word[WRC_ST_PDOWN]  = powerdown_flag_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // APB answer: one wait state, unmapped flagged as error
   // Read data is registered, so it stands only while pready_o is high
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
      begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end
      else
      begin
         pready_o  <= psel_i && penable_i && !pready_o;
         pslverr_o <= psel_i && penable_i && !pready_o && !addr_ok;
         prdata_o  <= 32'h0000_0000;
         if (rd_en)
            case (paddr_i)
               WRC_OFS_WDT_CTRL:  prdata_o <= {24'h0, wdt_enable_key_r, period_select_r};
               WRC_OFS_CAUSE:     prdata_o <= cause_word;
               WRC_OFS_LV_LEVEL:  prdata_o <= {24'h0, lowvolt_level_reg_r};
               WRC_OFS_LV_FILTER: prdata_o <= {30'h0, lowvolt_filter_sel_r};
               WRC_OFS_STATUS:    prdata_o <= status_word;
               default:           prdata_o <= 32'h0000_0000;
            endcase
      end
   end

endmodule

// *** tb/test_wrc_top.sv ***
// Self-checking bench for the watchdog and reset control block
module test_wrc_top;
   timeunit 1ns;
   timeprecision 1ps;
   import wrc_pkg::*;

   localparam int TICK = 3906;
   logic        clk_sys_i = 1'b0;
   logic        reset_i, psel_i, penable_i, pwrite_i, supply_low_i;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd_data;
   logic        pready_o, pslverr_o, rd_err, port_init_o, pc_zero_o;
   logic [1:0]  lv_threshold_o;
   wrc_cmd_t    core_cmd_i;
   wrc_rst_t    rst_req_o;
   int          bad_count = 0;
   int          total_checks = 0;
   logic [7:0]  codes [4] = '{WRC_LV_2V10, WRC_LV_2V55, WRC_LV_3V15, WRC_LV_3V80};

   // 125 MHz system clock
   always #4 clk_sys_i = ~clk_sys_i;

   wrc_top wrc_top_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .core_cmd_i(core_cmd_i), .supply_low_i(supply_low_i), .rst_req_o(rst_req_o),
      .lv_threshold_o(lv_threshold_o), .port_init_o(port_init_o), .pc_zero_o(pc_zero_o));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   // One APB transfer, held until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk_sys_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do
         @(posedge clk_sys_i);
      while (pready_o !== 1'b1 && n++ < 20);
      chk("pready", 32'h1, {31'h0, pready_o});
      rd_data = prdata_o;
      rd_err  = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd_data);
   endtask

   // Core command as a one-cycle pulse
   task automatic cmd(input logic [2:0] v);
      @(posedge clk_sys_i);
      core_cmd_i <= v;
      @(posedge clk_sys_i);
      core_cmd_i <= 3'h0;
   endtask

   // Full reset pulse must land within [lo, hi) cycles
   task automatic wait_full(input string name, input int lo, input int hi);
      int n = 0;
      while (rst_req_o.full_rst !== 1'b1 && n < hi)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(name, 32'h1, 32'(n >= lo && n < hi));
   endtask

   // No reset request of either kind over n cycles
   task automatic quiet(input string name, input int n);
      int hits = 0;
      repeat (n)
      begin
         @(posedge clk_sys_i);
         hits += int'(rst_req_o !== 2'b00);
      end
      chk(name, 32'h0, 32'(hits));
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard, well past the longest expected run
   initial
   begin
      #(90000 * 8);
      bad_count++;
      give_verdict;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      reset_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h000;
      pwdata_i = 32'h0;
      core_cmd_i = 3'h0;
      supply_low_i = 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk("init during reset", 32'h3, {30'h0, port_init_o, pc_zero_o});
      reset_i <= 1'b0;
      rd("ctrl reset", WRC_OFS_WDT_CTRL, 32'h53);
      chk("init released", 32'h0, {30'h0, port_init_o, pc_zero_o});
      rd("level reset", WRC_OFS_LV_LEVEL, 32'h55);
      rd("filter reset", WRC_OFS_LV_FILTER, 32'h0);
      rd("cause reset", WRC_OFS_CAUSE, 32'h0);
      rd("status reset", WRC_OFS_STATUS, 32'h0);
      rd("unmapped data", 12'h020, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, rd_err});
      apb(1'b1, WRC_OFS_LV_FILTER, 32'hFFFFFFFF);
      rd("filter upper", WRC_OFS_LV_FILTER, 32'h3);
      apb(1'b1, WRC_OFS_LV_FILTER, 32'h0);
      // Every level code and its threshold
      foreach (codes[i])
      begin
         apb(1'b1, WRC_OFS_LV_LEVEL, {24'h0, codes[i]});
         rd("level code", WRC_OFS_LV_LEVEL, {24'h0, codes[i]});
         chk("threshold", 32'(i), {30'h0, lv_threshold_o});
      end
      // Halt sets powerdown, clear drops it
      cmd(3'h2);
      rd("status halt", WRC_OFS_STATUS, 32'h2);
      cmd(3'h4);
      rd("status wake", WRC_OFS_STATUS, 32'h0);
      cmd(3'h2);
      cmd(3'h1);
      rd("status clear", WRC_OFS_STATUS, 32'h0);
      // Bad watchdog key: delayed reset and sticky flag
      apb(1'b1, WRC_OFS_WDT_CTRL, 32'h0);
      wait_full("key fault delay", 5900, 6200);
      rd("key flag", WRC_OFS_CAUSE, 32'h1);
      rd("ctrl restored", WRC_OFS_WDT_CTRL, 32'h53);
      apb(1'b1, WRC_OFS_CAUSE, 32'h1);
      rd("key flag kept", WRC_OFS_CAUSE, 32'h1);
      apb(1'b1, WRC_OFS_CAUSE, 32'h0);
      rd("key flag cleared", WRC_OFS_CAUSE, 32'h0);
      // Bad level code: flag at once, reset later, default back
      apb(1'b1, WRC_OFS_LV_LEVEL, 32'h0);
      rd("level flag", WRC_OFS_CAUSE, 32'h2);
      wait_full("level fault delay", 5880, 6200);
      rd("level restored", WRC_OFS_LV_LEVEL, 32'h55);
      apb(1'b1, WRC_OFS_CAUSE, 32'h0);
      // Short low stretch ignored, long one resets
      apb(1'b1, WRC_OFS_LV_LEVEL, 32'h33);
      supply_low_i <= 1'b1;
      quiet("short low", 5 * TICK);
      supply_low_i <= 1'b0;
      rd("no low flag", WRC_OFS_CAUSE, 32'h0);
      supply_low_i <= 1'b1;
      wait_full("low supply", 7 * TICK, 8 * TICK + 8);
      supply_low_i <= 1'b0;
      rd("low flag", WRC_OFS_CAUSE, 32'h4);
      rd("level kept", WRC_OFS_LV_LEVEL, 32'h33);
      give_verdict;
   end
endmodule

// *** tb/wrc_assertions.sv ***
// Concurrent checks on the ports of the watchdog and reset control block
module wrc_checker
(
   // Clock, reset and bus
   input wire logic               clk_sys_i,
   input wire logic               reset_i,
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pwrite_i,
   input wire logic [11:0]        paddr_i,
   input wire logic [31:0]        pwdata_i,
   input wire logic [31:0]        prdata_o,
   input wire logic               pready_o,
   input wire logic               pslverr_o,
   // Events and reset outputs
   input wire wrc_pkg::wrc_cmd_t  core_cmd_i,
   input wire logic               supply_low_i,
   input wire wrc_pkg::wrc_rst_t  rst_req_o,
   input wire logic [1:0]         lv_threshold_o,
   input wire logic               port_init_o,
   input wire logic               pc_zero_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import wrc_pkg::*;

   logic        wr_ok;
   logic        ctl_bad;
   logic        lvl_bad;
   logic        fault_go;
   logic [12:0] kf_cnt_r;
   logic        kf_seen_r;
   logic [16:0] low_cnt_r;
   logic        pd_r;

   ////////////////////////////////////////////////////////////////////////////
   // Committed writes only; a bad key starts the fault timer
   assign wr_ok    = psel_i && penable_i && pwrite_i && pready_o;
   assign ctl_bad  = !(pwdata_i[7:3] inside {WRC_KEY_EN_A, WRC_KEY_EN_B});
   assign lvl_bad  = !(pwdata_i[7:0] inside {WRC_LV_2V10, WRC_LV_2V55, WRC_LV_3V15, WRC_LV_3V80});
   assign fault_go = wr_ok && ((paddr_i == WRC_OFS_WDT_CTRL && ctl_bad) || (paddr_i == WRC_OFS_LV_LEVEL && lvl_bad));

   // Cycles since a bad key landed, stops past the window
   always_ff @(posedge clk_sys_i)
      if (reset_i || fault_go)
         kf_cnt_r <= {12'h000, !reset_i};
      else if (kf_cnt_r != 13'h0000 && kf_cnt_r < 13'h189C)
         kf_cnt_r <= kf_cnt_r + 13'h0001;
      else
         kf_cnt_r <= 13'h0000;

   // Full reset seen while the fault timer runs
   always_ff @(posedge clk_sys_i)
      if (reset_i || fault_go)
         kf_seen_r <= 1'b0;
      else if (rst_req_o.full_rst && kf_cnt_r != 13'h0000)
         kf_seen_r <= 1'b1;

   // Length of the current low-supply stretch, saturating
   always_ff @(posedge clk_sys_i)
      if (reset_i || !supply_low_i)
         low_cnt_r <= 17'h00000;
      else if (low_cnt_r != 17'h1FFFF)
         low_cnt_r <= low_cnt_r + 17'h00001;

   // Power-down as the core's commands leave it
   always_ff @(posedge clk_sys_i)
      if (reset_i)
         pd_r <= 1'b0;
      else if (core_cmd_i.halt)
         pd_r <= 1'b1;
      else if (core_cmd_i.clr || core_cmd_i.wake)
         pd_r <= 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   a_ready_after_access: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("ready missing after first access cycle");
   a_ready_one_cycle: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   a_err_unmapped: assert property (pready_o && paddr_i > WRC_OFS_COMMAND |-> pslverr_o)
      else $error("unmapped access without error");
   a_cause_upper_zero: assert property (pready_o && !pwrite_i && paddr_i == WRC_OFS_CAUSE |-> prdata_o[31:3] == 29'h0)
      else $error("cause upper bits not zero");
   a_filter_upper_zero: assert property (pready_o && !pwrite_i && paddr_i == WRC_OFS_LV_FILTER |-> prdata_o[31:2] == 30'h0)
      else $error("filter upper bits not zero");
   a_init_follows_reset: assert property (disable iff (1'b0) 1'b1 ##1 1'b1 |-> {port_init_o, pc_zero_o} == {2{$past(reset_i)}})
      else $error("init outputs do not follow power-on reset");
   a_threshold_map: assert property (wr_ok && paddr_i == WRC_OFS_LV_LEVEL && !lvl_bad |-> ##2 lv_threshold_o == {$past(pwdata_i[7], 2), $past(pwdata_i[1], 2)})
      else $error("threshold does not match level code");
   a_fault_not_early: assert property (kf_cnt_r != 13'h0000 && kf_cnt_r < 13'h170C |-> !rst_req_o.full_rst)
      else $error("key fault reset came too early");
   a_fault_fires: assert property (kf_cnt_r == 13'h1838 |-> kf_seen_r)
      else $error("key fault reset missing");
   a_lv_filtered: assert property (rst_req_o.full_rst && supply_low_i |-> low_cnt_r > 17'h06ACE)
      else $error("low supply reset before filter time");
   a_pcsp_only_asleep: assert property (rst_req_o.pc_sp_rst |-> $past(pd_r))
      else $error("program counter reset outside power-down");
endmodule

bind wrc_top wrc_checker wrc_checker_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .core_cmd_i(core_cmd_i), .supply_low_i(supply_low_i),
   .rst_req_o(rst_req_o), .lv_threshold_o(lv_threshold_o), .port_init_o(port_init_o), .pc_zero_o(pc_zero_o));
